// ---- rtl/acl_pkg.sv ----
package acl_pkg;

  localparam int NRULE = 16;

  // register port word addresses
  localparam logic [7:0] ADDR_MATCH_BASE = 8'h00;
  localparam logic [7:0] ADDR_ACTION_BASE = 8'h40;
  localparam logic [7:0] ADDR_ENTRY_BASE = 8'h50;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h61;
  localparam logic [7:0] ADDR_COUNT_BASE = 8'h70;

  // matching rule words inside one four-word slot
  localparam logic [1:0] MW_CTRL = 2'h0;
  localparam logic [1:0] MW_VAL0 = 2'h1;
  localparam logic [1:0] MW_VAL1 = 2'h2;
  localparam logic [1:0] MW_VAL2 = 2'h3;

  // matching rule control word fields
  localparam int MR_LAYER_LSB = 0;
  localparam int MR_OPT_LSB = 2;
  localparam int MR_SIDE_BIT = 4;
  localparam int MR_POL_BIT = 5;

  // action rule fields; count value spans the priority and remark fields
  localparam int ACT_COUNT_LSB = 0;
  localparam int ACT_COUNT_W = 11;
  localparam int ACT_TU_BIT = 11;
  localparam int ACT_CA_BIT = 12;

  // processing entry fields
  localparam int PE_MASK_LSB = 0;
  localparam int PE_PTR_LSB = 16;

  // layer select and compare option codes
  localparam logic [1:0] LAYER_OFF = 2'h0;
  localparam logic [1:0] LAYER_L2 = 2'h1;
  localparam logic [1:0] LAYER_L3 = 2'h2;
  localparam logic [1:0] LAYER_L4 = 2'h3;
  localparam logic [1:0] OPT_L2_COUNT = 2'h0;
  localparam logic [1:0] OPT_L2_MAC = 2'h1;
  localparam logic [1:0] OPT_L2_TYPE = 2'h2;
  localparam logic [1:0] OPT_L3_MASKED = 2'h1;
  localparam logic [1:0] OPT_L3_PAIR = 2'h2;
  localparam logic [1:0] OPT_L4_PROTO = 2'h0;
  localparam logic [1:0] OPT_L4_TCP = 2'h1;
  localparam logic [1:0] OPT_L4_UDP = 2'h2;
  localparam logic [1:0] OPT_L4_SEQ = 2'h3;

  // reset values
  localparam logic [31:0] MR_RESET = 32'h0000_0000;
  localparam logic [31:0] ACT_RESET = 32'h0000_0000;
  localparam logic [31:0] PE_RESET = 32'h0000_0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

  // count time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIME_US_NS = 1000;
  localparam int CYC_PER_US = (TIME_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;

  typedef enum logic {CNT_IDLE, CNT_RUN} acl_cnt_state_t;

endpackage

// ---- rtl/acl_rule_engine.sv ----
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module acl_rule_engine
  import acl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [31:0] reg_rd_data,
  // parsed packet header
  input wire logic pkt_valid,
  input wire logic [47:0] pkt_mac_dst,
  input wire logic [47:0] pkt_mac_src,
  input wire logic [15:0] pkt_ethertype,
  input wire logic pkt_ip_valid,
  input wire logic [31:0] pkt_ip_src,
  input wire logic [31:0] pkt_ip_dst,
  input wire logic [7:0] pkt_ip_proto,
  input wire logic pkt_is_tcp,
  input wire logic pkt_is_udp,
  input wire logic [15:0] pkt_port_src,
  input wire logic [15:0] pkt_port_dst,
  input wire logic [31:0] pkt_tcp_seq,
  // action result
  output logic act_valid,
  output logic act_hit,
  output logic [3:0] act_index,
  output logic [31:0] act_rule,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic is_count(input logic [31:0] c);
    return (c[MR_LAYER_LSB +: 2] == LAYER_L2) && (c[MR_OPT_LSB +: 2] == OPT_L2_COUNT);
  endfunction
  // reads the packet ports directly; one call per rule
  function automatic logic rule_match(input logic [31:0] c, input logic [31:0] v0, input logic [31:0] v1,
                                      input logic [31:0] v2);
    logic [1:0] lay;
    logic [1:0] opt;
    logic side;
    logic eq;
    logic ok;
    logic [47:0] mac;
    logic [31:0] ip;
    logic [15:0] port;
    lay = c[MR_LAYER_LSB +: 2];
    opt = c[MR_OPT_LSB +: 2];
    side = c[MR_SIDE_BIT];
    eq = 1'b0;
    ok = 1'b0;
    mac = side ? pkt_mac_src : pkt_mac_dst;
    ip = side ? pkt_ip_src : pkt_ip_dst;
    port = side ? pkt_port_src : pkt_port_dst;
    case (lay)
      LAYER_L2: begin
        ok = 1'b1;
        case (opt)
          OPT_L2_MAC: eq = (mac == {v1[15:0], v0});
          OPT_L2_TYPE: eq = (pkt_ethertype == v1[31:16]);
          default: eq = (mac == {v1[15:0], v0}) && (pkt_ethertype == v1[31:16]);
        endcase
      end
      LAYER_L3: begin
        ok = pkt_ip_valid && ((opt == OPT_L3_MASKED) || (opt == OPT_L3_PAIR));
        if (opt == OPT_L3_MASKED) begin
          eq = (((ip ^ v0) & ~v2) == 32'h0000_0000);
        end else begin
          eq = (pkt_ip_src == v0) && (pkt_ip_dst == v2);
        end
      end
      LAYER_L4: begin
        case (opt)
          OPT_L4_PROTO: begin
            ok = pkt_ip_valid;
            eq = (pkt_ip_proto == v0[7:0]);
          end
          OPT_L4_TCP: begin
            ok = pkt_is_tcp;
            eq = (port == v0[15:0]);
          end
          OPT_L4_UDP: begin
            ok = pkt_is_udp;
            eq = (port == v0[15:0]);
          end
          default: begin
            ok = pkt_is_tcp;
            eq = (pkt_tcp_seq == v0);
          end
        endcase
      end
      default: ok = 1'b0;
    endcase
    return ok && (c[MR_POL_BIT] ? eq : !eq);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [31:0] mr_ctrl_q [NRULE];
  logic [31:0] mr_v0_q [NRULE];
  logic [31:0] mr_v1_q [NRULE];
  logic [31:0] mr_v2_q [NRULE];
  logic [31:0] act_q [NRULE];
  logic [31:0] pe_q [NRULE];
  logic [15:0] irq_st_q;
  logic [15:0] irq_st_d;
  logic [15:0] irq_mask_q;
  logic [31:0] rd_data_q;
  logic [31:0] rd_mux;
  wire [3:0] reg_idx = reg_addr[5:2];
  wire [3:0] reg_low = reg_addr[3:0];
  wire sel_match = (reg_addr[7:6] == ADDR_MATCH_BASE[7:6]);
  wire sel_action = (reg_addr[7:4] == ADDR_ACTION_BASE[7:4]);
  wire sel_entry = (reg_addr[7:4] == ADDR_ENTRY_BASE[7:4]);
  wire sel_count = (reg_addr[7:4] == ADDR_COUNT_BASE[7:4]);
  wire wr_match = reg_wr_en && sel_match;
  wire wr_action = reg_wr_en && sel_action;
  wire wr_entry = reg_wr_en && sel_entry;
  wire wr_irq_st = reg_wr_en && (reg_addr == ADDR_IRQ_STATUS);
  wire wr_irq_mask = reg_wr_en && (reg_addr == ADDR_IRQ_MASK);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NRULE; i++) begin
        mr_ctrl_q[i] <= MR_RESET;
        mr_v0_q[i] <= MR_RESET;
        mr_v1_q[i] <= MR_RESET;
        mr_v2_q[i] <= MR_RESET;
      end
    end else if (wr_match) begin
      case (reg_addr[1:0])
        MW_CTRL: mr_ctrl_q[reg_idx] <= reg_wr_data;
        MW_VAL0: mr_v0_q[reg_idx] <= reg_wr_data;
        MW_VAL1: mr_v1_q[reg_idx] <= reg_wr_data;
        default: mr_v2_q[reg_idx] <= reg_wr_data;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NRULE; i++) begin
        act_q[i] <= ACT_RESET;
        pe_q[i] <= PE_RESET;
      end
    end else begin
      if (wr_action) begin
        act_q[reg_low] <= reg_wr_data;
      end
      if (wr_entry) begin
        pe_q[reg_low] <= reg_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage 1: evaluate every matching rule
  logic [15:0] match_d;
  logic [15:0] match_q;
  logic valid_q;
  always_comb begin
    for (int i = 0; i < NRULE; i++) begin
      match_d[i] = rule_match(mr_ctrl_q[i], mr_v0_q[i], mr_v1_q[i], mr_v2_q[i]);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      match_q <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      match_q <= pkt_valid ? match_d : 16'h0000;
      valid_q <= pkt_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage 2: processing entries and action choice
  logic [15:0] act_vec;
  logic [3:0] win_idx;
  logic [15:0] sel_mask;
  logic [3:0] ptr;
  always_comb begin
    act_vec = 16'h0000;
    sel_mask = 16'h0000;
    ptr = 4'h0;
    for (int e = 0; e < NRULE; e++) begin
      sel_mask = pe_q[e][PE_MASK_LSB +: 16];
      ptr = pe_q[e][PE_PTR_LSB +: 4];
      // an empty mask would be vacuously true; treat it as an unused entry
      if ((sel_mask != 16'h0000) && ((sel_mask & ~match_q) == 16'h0000) && !is_count(mr_ctrl_q[ptr])) begin
        act_vec[ptr] = 1'b1;
      end
    end
  end
  always_comb begin
    win_idx = 4'h0;
    for (int a = NRULE - 1; a >= 0; a--) begin
      if (act_vec[a]) begin
        win_idx = 4'(a);
      end
    end
  end

  logic act_valid_q;
  logic act_hit_q;
  logic [3:0] act_index_q;
  logic [31:0] act_rule_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      act_valid_q <= 1'b0;
      act_hit_q <= 1'b0;
      act_index_q <= 4'h0;
      act_rule_q <= 32'h0000_0000;
    end else begin
      act_valid_q <= valid_q;
      act_hit_q <= valid_q && (act_vec != 16'h0000);
      act_index_q <= (valid_q && (act_vec != 16'h0000)) ? win_idx : 4'h0;
      act_rule_q <= (valid_q && (act_vec != 16'h0000)) ? act_q[win_idx] : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count time base
  logic [7:0] us_div_q;
  logic [9:0] ms_div_q;
  logic us_tick_q;
  logic ms_tick_q;
  wire us_wrap = (us_div_q == 8'(CYC_PER_US - 1));
  wire ms_wrap = us_wrap && (ms_div_q == 10'(US_PER_MS - 1));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      us_div_q <= 8'h00;
      ms_div_q <= 10'h000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end else begin
      us_div_q <= us_wrap ? 8'h00 : us_div_q + 8'h01;
      if (us_wrap) begin
        ms_div_q <= ms_wrap ? 10'h000 : ms_div_q + 10'h001;
      end
      us_tick_q <= us_wrap;
      ms_tick_q <= ms_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-rule counters
  logic [10:0] cnt_q [NRULE];
  logic [10:0] cnt_d [NRULE];
  acl_cnt_state_t cst_q [NRULE];
  acl_cnt_state_t cst_d [NRULE];
  logic [15:0] cnt_evt;
  always_comb begin
    logic [10:0] cv;
    logic tick;
    logic hit;
    cv = 11'h000;
    tick = 1'b0;
    hit = 1'b0;
    cnt_evt = 16'h0000;
    for (int i = 0; i < NRULE; i++) begin
      cv = act_q[i][ACT_COUNT_LSB +: ACT_COUNT_W];
      tick = act_q[i][ACT_TU_BIT] ? ms_tick_q : us_tick_q;
      hit = valid_q && match_q[i];
      cnt_d[i] = cnt_q[i];
      cst_d[i] = cst_q[i];
      if (!is_count(mr_ctrl_q[i])) begin
        cnt_d[i] = 11'h000;
        cst_d[i] = CNT_IDLE;
      end else if (!act_q[i][ACT_CA_BIT]) begin
        // timeout: each match reloads, expiry is a missed packet
        case (cst_q[i])
          CNT_IDLE: begin
            if (hit) begin
              cnt_d[i] = cv;
              cst_d[i] = CNT_RUN;
            end
          end
          CNT_RUN: begin
            if (hit) begin
              cnt_d[i] = cv;
            end else if (tick) begin
              if (cnt_q[i] <= 11'h001) begin
                cnt_d[i] = 11'h000;
                cst_d[i] = CNT_IDLE;
                cnt_evt[i] = 1'b1;
              end else begin
                cnt_d[i] = cnt_q[i] - 11'h001;
              end
            end
          end
          default: cst_d[i] = CNT_IDLE;
        endcase
      end else begin
        cst_d[i] = CNT_IDLE;
        if (hit) begin
          if (cnt_q[i] + 11'h001 >= cv) begin
            cnt_d[i] = 11'h000;
            cnt_evt[i] = 1'b1;
          end else begin
            cnt_d[i] = cnt_q[i] + 11'h001;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NRULE; i++) begin
        cnt_q[i] <= 11'h000;
        cst_q[i] <= CNT_IDLE;
      end
    end else begin
      cnt_q <= cnt_d;
      cst_q <= cst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and read back
  // a counter event in the clearing cycle survives the write-one-to-clear
  assign irq_st_d = (irq_st_q & ~(wr_irq_st ? reg_wr_data[15:0] : 16'h0000)) | cnt_evt;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_st_q <= 16'h0000;
      irq_mask_q <= IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      if (wr_irq_mask) begin
        irq_mask_q <= reg_wr_data[15:0];
      end
      irq <= |(irq_st_q & irq_mask_q);
    end
  end
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_match) begin
      case (reg_addr[1:0])
        MW_CTRL: rd_mux = mr_ctrl_q[reg_idx];
        MW_VAL0: rd_mux = mr_v0_q[reg_idx];
        MW_VAL1: rd_mux = mr_v1_q[reg_idx];
        default: rd_mux = mr_v2_q[reg_idx];
      endcase
    end else if (sel_action) begin
      rd_mux = act_q[reg_low];
    end else if (sel_entry) begin
      rd_mux = pe_q[reg_low];
    end else if (sel_count) begin
      rd_mux = {20'h00000, (cst_q[reg_low] == CNT_RUN), cnt_q[reg_low]};
    end else if (reg_addr == ADDR_IRQ_STATUS) begin
      rd_mux = {16'h0000, irq_st_q};
    end else if (reg_addr == ADDR_IRQ_MASK) begin
      rd_mux = {16'h0000, irq_mask_q};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= reg_rd_en ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rd_data = rd_data_q;
  assign act_valid = act_valid_q;
  assign act_hit = act_hit_q;
  assign act_index = act_index_q;
  assign act_rule = act_rule_q;
endmodule

// ---- verification/acl_checker.sv ----
`timescale 1ns/1ps
module acl_checker
  import acl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_rd_data,
  // packet, result and interrupt
  input wire logic pkt_valid,
  input wire logic act_valid,
  input wire logic act_hit,
  input wire logic [3:0] act_index,
  input wire logic [31:0] act_rule,
  input wire logic irq
);
////////////////////////////////////////////////////////////
  // shadow of the mask; irq cannot be judged without it
  logic [15:0] mask_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= 16'h0000;
    end else if (reg_wr_en && reg_addr == ADDR_IRQ_MASK) begin
      mask_q <= reg_wr_data[15:0];
    end
  end
////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_result_latency: assert property (pkt_valid |-> ##2 act_valid)
    else $error("result missing two cycles after packet");
  a_result_cause: assert property (act_valid |-> $past(pkt_valid, 2))
    else $error("result without a packet");
  a_back_to_back: assert property (pkt_valid [*2] |-> ##1 act_valid [*2])
    else $error("back to back packet lost");
  a_miss_zeroed: assert property (act_valid && !act_hit |-> act_index == 4'h0 && act_rule == 32'h0)
    else $error("miss carries an action");
  a_idle_quiet: assert property (!act_valid |-> !act_hit && act_index == 4'h0 && act_rule == 32'h0)
    else $error("action outside a result cycle");
  a_irq_masked: assert property (mask_q == 16'h0 && $past(mask_q) == 16'h0 |-> !irq)
    else $error("irq with all sources masked");
  a_rd_pulse: assert property (!$past(reg_rd_en) |-> reg_rd_data == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_read: assert property (reg_rd_en && reg_addr inside {[8'h62:8'h6f]} |=> reg_rd_data == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind acl_rule_engine acl_checker acl_checker_inst (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .pkt_valid(pkt_valid), .act_valid(act_valid), .act_hit(act_hit), .act_index(act_index),
  .act_rule(act_rule), .irq(irq));

// ---- verification/acl_parser_model.sv ----
`timescale 1ns/1ps
module acl_parser_model #(
  parameter logic [31:0] IPA = 32'h0000_0000,
  parameter logic [15:0] PRT = 16'h0000
) (
  // clock
  input wire logic mclk,
  // parsed header
  output logic pkt_valid,
  output logic [47:0] pkt_mac_dst,
  output logic [47:0] pkt_mac_src,
  output logic [15:0] pkt_ethertype,
  output logic pkt_ip_valid,
  output logic [31:0] pkt_ip_src,
  output logic [31:0] pkt_ip_dst,
  output logic [7:0] pkt_ip_proto,
  output logic pkt_is_tcp,
  output logic pkt_is_udp,
  output logic [15:0] pkt_port_src,
  output logic [15:0] pkt_port_dst,
  output logic [31:0] pkt_tcp_seq
);
  logic [250:0] hdr;
  assign {pkt_mac_dst, pkt_mac_src, pkt_ethertype, pkt_ip_valid, pkt_ip_src, pkt_ip_dst, pkt_ip_proto,
    pkt_is_tcp, pkt_is_udp, pkt_port_src, pkt_port_dst, pkt_tcp_seq} = hdr;
  initial begin
    pkt_valid = 1'b0;
    hdr = '0;
  end
////////////////////////////////////////////////////////////
  // tcp over ipv4 only; released fields are inverted so a stale header never matches by luck
  task automatic send(input logic [47:0] md, input logic [15:0] et, input int n);
    @(posedge mclk);
    pkt_valid <= 1'b1;
    hdr <= {md, md + 48'h1, et, 1'b1, IPA + 32'h1, IPA, 8'h06, 1'b1, 1'b0, PRT + 16'h1, PRT, IPA};
    repeat (n) @(posedge mclk);
    pkt_valid <= 1'b0;
    hdr <= ~hdr;
  endtask
endmodule

// ---- verification/tb_acl_rule_engine.sv ----
`timescale 1ns/1ps
module tb_acl_rule_engine
  import acl_pkg::*;
;
  localparam logic [47:0] MAC = 48'h0a0b_0c0d_0e0f;
  localparam logic [15:0] ETY = 16'h88b5;
  localparam logic [31:0] IPA = 32'hc0a8_0a01;
  localparam logic [15:0] PRT = 16'h0050;
  localparam logic [31:0] A2 = 32'h7700_0002;
  localparam logic [31:0] A5 = 32'h5500_0005;
  localparam logic [31:0] ML = MAC[31:0];
  localparam logic [31:0] MH = {16'h0000, MAC[47:32]};
  // one row per L2 compare, L3 and L4 option code, plus a source-MAC row and one off-layer row, matching the fixed header of the parser model
  localparam logic [5:0] TC [13] = '{6'h05, 6'h09, 6'h0d, 6'h15, 6'h06, 6'h0a, 6'h02, 6'h0e, 6'h03, 6'h07,
    6'h0b, 6'h0f, 6'h0c};
  localparam logic [31:0] TV0 [13] = '{ML, 32'h0, ML, ML + 32'h1, IPA ^ 32'hff, IPA + 32'h1, IPA, IPA,
    32'h6, {16'h0, PRT}, {16'h0, PRT}, IPA, ML};
  localparam logic [31:0] TV1 [13] = '{MH, {ETY, 16'h0}, {ETY, MAC[47:32]}, MH, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, {ETY, MAC[47:32]}};
  localparam logic [12:0] TOK = 13'b0_1011_0011_1111;
  logic mclk;
  logic rstn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wr_data;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [31:0] reg_rd_data;
  logic pkt_valid;
  logic [47:0] pkt_mac_dst;
  logic [47:0] pkt_mac_src;
  logic [15:0] pkt_ethertype;
  logic pkt_ip_valid;
  logic [31:0] pkt_ip_src;
  logic [31:0] pkt_ip_dst;
  logic [7:0] pkt_ip_proto;
  logic pkt_is_tcp;
  logic pkt_is_udp;
  logic [15:0] pkt_port_src;
  logic [15:0] pkt_port_dst;
  logic [31:0] pkt_tcp_seq;
  logic act_valid;
  logic act_hit;
  logic [3:0] act_index;
  logic [31:0] act_rule;
  logic irq;
  int err_count;
  int n_checks;
  int cyc;
////////////////////////////////////////////////////////////
  acl_rule_engine acl_rule_engine_inst (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .pkt_valid(pkt_valid), .pkt_mac_dst(pkt_mac_dst), .pkt_mac_src(pkt_mac_src), .pkt_ethertype(pkt_ethertype),
    .pkt_ip_valid(pkt_ip_valid), .pkt_ip_src(pkt_ip_src), .pkt_ip_dst(pkt_ip_dst), .pkt_ip_proto(pkt_ip_proto),
    .pkt_is_tcp(pkt_is_tcp), .pkt_is_udp(pkt_is_udp), .pkt_port_src(pkt_port_src),
    .pkt_port_dst(pkt_port_dst), .pkt_tcp_seq(pkt_tcp_seq), .act_valid(act_valid), .act_hit(act_hit),
    .act_index(act_index), .act_rule(act_rule), .irq(irq));
  acl_parser_model #(.IPA(IPA), .PRT(PRT)) acl_parser_model_inst (.mclk(mclk), .pkt_valid(pkt_valid),
    .pkt_mac_dst(pkt_mac_dst), .pkt_mac_src(pkt_mac_src), .pkt_ethertype(pkt_ethertype),
    .pkt_ip_valid(pkt_ip_valid), .pkt_ip_src(pkt_ip_src), .pkt_ip_dst(pkt_ip_dst), .pkt_ip_proto(pkt_ip_proto),
    .pkt_is_tcp(pkt_is_tcp), .pkt_is_udp(pkt_is_udp), .pkt_port_src(pkt_port_src),
    .pkt_port_dst(pkt_port_dst), .pkt_tcp_seq(pkt_tcp_seq));
////////////////////////////////////////////////////////////
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    #1 cmp(nm, exp, reg_rd_data);
  endtask
  task automatic chk_act(input logic h, input logic [3:0] i, input logic [31:0] r);
    cmp("act_valid", 32'h1, 32'(act_valid));
    cmp("act_hit", 32'(h), 32'(act_hit));
    cmp("act_index", 32'(i), 32'(act_index));
    cmp("act_rule", h ? r : 32'h0, act_rule);
  endtask
  // result lands two cycles after the packet cycle
  task automatic pkt(input logic [47:0] md, input logic [15:0] et, input logic h, input logic [3:0] i,
    input logic [31:0] r);
    acl_parser_model_inst.send(md, et, 1);
    @(posedge mclk);
    #1 chk_act(h, i, r);
  endtask
  task automatic rule(input logic [3:0] n, input logic [5:0] c, input logic [31:0] v0, input logic [31:0] v1,
    input logic [31:0] v2);
    wr({2'b00, n, MW_VAL0}, v0);
    wr({2'b00, n, MW_VAL1}, v1);
    wr({2'b00, n, MW_VAL2}, v2);
    wr({2'b00, n, MW_CTRL}, {26'h0, c});
  endtask
////////////////////////////////////////////////////////////
  initial begin
    logic h;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 32'h0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd(ADDR_IRQ_MASK, 32'h0, "irq_mask");
    wr(8'h62, 32'hffff_ffff);
    rd(8'h62, 32'h0, "unmapped");
    pkt(MAC, ETY, 1'b0, 4'h0, 32'h0);
    wr(ADDR_ACTION_BASE + 8'h5, A5);
    wr(ADDR_ENTRY_BASE, 32'h0005_0001);
    rd(ADDR_ENTRY_BASE, 32'h0005_0001, "entry0");
    for (int i = 0; i < 13; i++) begin
      rule(4'h0, TC[i], TV0[i], TV1[i], (i == 4) ? 32'hff : ((i == 5) ? IPA : 32'h0));
      for (int p = 0; p < 2; p++) begin
        wr(ADDR_MATCH_BASE, {26'h0, TC[i] | (p[0] ? 6'h20 : 6'h00)});
        h = TOK[i] && p[0];
        pkt(MAC, ETY, h, h ? 4'h5 : 4'h0, A5);
      end
    end
    rule(4'h0, 6'h25, ML, MH, 32'h0);
    rule(4'h1, 6'h29, 32'h0, {ETY, 16'h0}, 32'h0);
    rule(4'h2, 6'h25, 32'h0, MH, 32'h0);
    wr(ADDR_ACTION_BASE + 8'h1, 32'h1100_0001);
    wr(ADDR_ACTION_BASE + 8'h2, A2);
    wr(ADDR_ENTRY_BASE + 8'h1, 32'h0005_0002);
    wr(ADDR_ENTRY_BASE + 8'h2, 32'h0002_0003);
    wr(ADDR_ENTRY_BASE + 8'h3, 32'h0001_0005);
    pkt(MAC, ETY, 1'b1, 4'h2, A2);
    pkt(MAC + 48'h100, ETY, 1'b1, 4'h5, A5);
    pkt(MAC, ETY ^ 16'h1, 1'b1, 4'h5, A5);
    pkt(MAC + 48'h100, ETY ^ 16'h1, 1'b0, 4'h0, 32'h0);
    acl_parser_model_inst.send(MAC + 48'h100, ETY, 2);
    #1 chk_act(1'b1, 4'h5, A5);
    @(posedge mclk);
    #1 chk_act(1'b1, 4'h5, A5);
    // counting pair at index 3; upper action bits must not leak into the count
    rule(4'h3, 6'h21, ML, {ETY, MAC[47:32]}, 32'h0);
    wr(ADDR_ACTION_BASE + 8'h3, 32'hf000_1003);
    wr(ADDR_ENTRY_BASE + 8'h4, 32'h0003_0008);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        rd(ADDR_IRQ_STATUS, 32'h0, "irq_status");
        rd(ADDR_COUNT_BASE + 8'h3, 32'h2, "count");
      end
      pkt(MAC, ETY, 1'b1, 4'h2, A2);
    end
    rd(ADDR_IRQ_STATUS, 32'h8, "irq_status");
    cmp("irq", 32'h0, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'h8);
    repeat (2) @(posedge mclk);
    #1 cmp("irq", 32'h1, 32'(irq));
    wr(ADDR_IRQ_STATUS, 32'h8);
    repeat (2) @(posedge mclk);
    #1 cmp("irq", 32'h0, 32'(irq));
    wr(ADDR_ACTION_BASE + 8'h3, 32'h0000_0002);
    pkt(MAC, ETY, 1'b1, 4'h2, A2);
    repeat (230) @(posedge mclk);
    rd(ADDR_IRQ_STATUS, 32'h0, "irq_status");
    repeat (300) @(posedge mclk);
    rd(ADDR_IRQ_STATUS, 32'h8, "irq_status");
    #1 cmp("irq", 32'h1, 32'(irq));
    // millisecond unit: the first slow tick lies far beyond this run, so the count must stay loaded
    wr(ADDR_IRQ_STATUS, 32'h8);
    wr(ADDR_ACTION_BASE + 8'h3, 32'h0000_0801);
    pkt(MAC, ETY, 1'b1, 4'h2, A2);
    repeat (300) @(posedge mclk);
    rd(ADDR_COUNT_BASE + 8'h3, 32'h801, "count");
    rd(ADDR_IRQ_STATUS, 32'h0, "irq_status");
    results();
  end
endmodule
